// File: hw/serialization_unit.sv
// Purpose: decide when fetch and execute stall for serializing operations
// Assumes: decode supplies an operation class; memory side reports drain status
// Notes: fences go to the tracker and do not stop the front end
`include "serial_defines.svh"
`timescale 1ns/1ns
module serialization_unit (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic OP_VALID,
  input wire serial_pkg::opc_t OP_CLASS,
  input wire serial_pkg::word_t OP_DATA,
  input wire logic OLDER_RETIRED,
  input wire logic STORE_BUF_EMPTY,
  input wire logic MEM_IDLE,
  input wire logic LOADS_DONE,
  input wire logic WBACK_DONE,
  output logic OP_ACCEPT,
  output logic FETCH_HOLD,
  output logic FLUSH_YOUNGER,
  output logic OP_DONE,
  output logic ID_REGS_WRITE,
  output logic WBACK_ALL,
  output logic TLB_FLUSH_NONGLOBAL,
  output logic STORE_HOLD,
  output logic LOAD_HOLD,
  output serial_pkg::word_t PRIMARY_CTRL,
  output serial_pkg::word_t PAGE_BASE,
  output logic FETCH_PAGING,
  output logic FENCE_BUSY
);
  import serial_pkg::*;

  ser_state_e state;
  ser_state_e next_state;
  opc_t held_op;
  word_t held_data;
  logic wback_wait;
  logic wback_seen;
  fence_if fi ();

  // Decode of the incoming class
  wire is_priv_ser = (OP_CLASS >= `OPC_CTRL_WRITE) && (OP_CLASS <= `OPC_TASK_REG_LOAD);
  wire is_user_ser = (OP_CLASS == `OPC_IDENTIFICATION_QUERY)
    || (OP_CLASS == `OPC_INTERRUPT_RETURN) || (OP_CLASS == `OPC_SYSTEM_MGMT_RESUME);
  wire is_base = (OP_CLASS == `OPC_BASE_WRITE);
  // Base writes also serialize so the next fetch sees the new tables
  wire is_ser = is_priv_ser | is_user_ser | is_base;
  wire is_store_fence_op = OP_CLASS == `OPC_STORE_FENCE;
  wire is_load_fence_op = OP_CLASS == `OPC_LOAD_FENCE;
  wire is_full_fence_op = OP_CLASS == `OPC_FULL_FENCE;
  // Branches are ordinary ops: prefetch may run ahead of them
  wire is_branch = OP_CLASS == `OPC_BRANCH;
  wire take = OP_VALID & (state == ST_RUN);
  wire take_ser = take & is_ser;
  // Drain: older work retired, stores out, bus idle; cache lines stay put
  wire drained = OLDER_RETIRED & STORE_BUF_EMPTY & MEM_IDLE;
  wire held_wback = held_op == `OPC_CACHE_WRITEBACK_INVALIDATE;
  // A done pulse that lands before the drain finishes is remembered
  wire wback_ok = ~held_wback | wback_seen | (wback_wait & WBACK_DONE);
  wire held_ctrl = held_op == `OPC_CTRL_WRITE;
  wire held_base = held_op == `OPC_BASE_WRITE;
  wire paging_on = PRIMARY_CTRL[`PAGING_BIT];

  // Sequencer: run, drain older work, apply, then restart fetch
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (take_ser) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (drained && wback_ok && !fi.busy) begin
          next_state = ST_APPLY;
        end
      end
      ST_APPLY: begin
        next_state = ST_REFETCH;
      end
      ST_REFETCH: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Fence requests; full fence asks for both kinds
  assign fi.req_store = take & (is_store_fence_op | is_full_fence_op);
  assign fi.req_load = take & (is_load_fence_op | is_full_fence_op);
  assign fi.store_empty = STORE_BUF_EMPTY;
  assign fi.loads_done = LOADS_DONE;

  fence_tracker u_fence (
    .CLOCK(CLOCK),
    .RST_B(RST_B),
    .f(fi.trk)
  );

  // State and captured operation
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_RUN;
      held_op <= `OPC_NONE;
      held_data <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (take_ser) begin
        held_op <= OP_CLASS;
        held_data <= OP_DATA;
      end
    end
  end

  // Writeback-invalidate request: raised once, held until done
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wback_wait <= 1'b0;
      wback_seen <= 1'b0;
      WBACK_ALL <= 1'b0;
    end else begin
      // Clear first so a new request in the same cycle wins
      if (WBACK_DONE) begin
        WBACK_ALL <= 1'b0;
      end
      if (wback_wait && WBACK_DONE) begin
        wback_seen <= 1'b1;
      end
      if (take_ser && OP_CLASS == `OPC_CACHE_WRITEBACK_INVALIDATE) begin
        wback_wait <= 1'b1;
        wback_seen <= 1'b0;
        WBACK_ALL <= 1'b1;
      end else if (state == ST_APPLY) begin
        wback_wait <= 1'b0;
        wback_seen <= 1'b0;
      end
    end
  end

  // Architectural control state changes only after the drain
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      PRIMARY_CTRL <= `CTRL_RESET;
      PAGE_BASE <= `BASE_RESET;
      TLB_FLUSH_NONGLOBAL <= 1'b0;
      ID_REGS_WRITE <= 1'b0;
      OP_DONE <= 1'b0;
    end else begin
      TLB_FLUSH_NONGLOBAL <= 1'b0;
      ID_REGS_WRITE <= 1'b0;
      OP_DONE <= 1'b0;
      if (state == ST_APPLY) begin
        OP_DONE <= 1'b1;
        if (held_ctrl) begin
          PRIMARY_CTRL <= held_data;
        end
        if (held_base) begin
          PAGE_BASE <= held_data;
          TLB_FLUSH_NONGLOBAL <= paging_on;
        end
        // Only side effect: the four result registers
        ID_REGS_WRITE <= held_op == `OPC_IDENTIFICATION_QUERY;
      end
    end
  end

  // Fetch translation mode follows control only at the refetch point
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      FETCH_PAGING <= 1'b0;
    end else if (state == ST_REFETCH) begin
      FETCH_PAGING <= paging_on;
    end
  end

  // Front-end hold and flush; fences never raise these
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      FETCH_HOLD <= 1'b0;
      FLUSH_YOUNGER <= 1'b0;
      OP_ACCEPT <= 1'b0;
      STORE_HOLD <= 1'b0;
      LOAD_HOLD <= 1'b0;
      FENCE_BUSY <= 1'b0;
    end else begin
      FETCH_HOLD <= (next_state != ST_RUN);
      // Speculative results past the serializer are discarded
      FLUSH_YOUNGER <= take_ser;
      OP_ACCEPT <= take & ~is_branch | take & is_branch;
      STORE_HOLD <= fi.hold_store | (next_state == ST_DRAIN);
      LOAD_HOLD <= fi.hold_load | (next_state == ST_DRAIN);
      FENCE_BUSY <= fi.busy;
    end
  end
endmodule : serialization_unit

// File: shared/serial_defines.svh
// Purpose: constants for the instruction serialization unit
// Assumes: included by bare name, definitions only
// Notes: opcode classes are decoded upstream into a small class code
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH
`define OPC_W 5
`define OPC_NONE 5'h00
`define OPC_CTRL_WRITE 5'h01
`define OPC_DEBUG_WRITE 5'h02
`define OPC_MODEL_SPECIFIC_REG_WRITE 5'h03
`define OPC_CACHE_INVALIDATE 5'h04
`define OPC_PAGE_ENTRY_INVALIDATE 5'h05
`define OPC_CACHE_WRITEBACK_INVALIDATE 5'h06
`define OPC_GLOBAL_DT_LOAD 5'h07
`define OPC_LOCAL_DT_LOAD 5'h08
`define OPC_INTERRUPT_DT_LOAD 5'h09
`define OPC_TASK_REG_LOAD 5'h0a
`define OPC_IDENTIFICATION_QUERY 5'h0b
`define OPC_INTERRUPT_RETURN 5'h0c
`define OPC_SYSTEM_MGMT_RESUME 5'h0d
`define OPC_STORE_FENCE 5'h0e
`define OPC_LOAD_FENCE 5'h0f
`define OPC_FULL_FENCE 5'h10
`define OPC_BRANCH 5'h11
`define OPC_BASE_WRITE 5'h12
`define CR_W 32
`define PAGING_BIT 31
`define PROT_BIT 0
`define CTRL_RESET 32'h0000_0000
`define BASE_RESET 32'h0000_0000
`define DRAIN_WAIT_CYCLES 8'h01
`endif

// File: shared/serial_pkg.sv
// Purpose: types for the instruction serialization unit
// Assumes: serial_defines.svh is on the include path
// Notes: state codes are one-hot
package serial_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_APPLY = 4'b0100,
    ST_REFETCH = 4'b1000
  } ser_state_e;
  typedef logic [4:0] opc_t;
  typedef logic [31:0] word_t;
endpackage : serial_pkg

// File: shared/fence_if.sv
// Purpose: fence request and drain status between top and fence tracker
// Assumes: single core clock
// Notes: requests are one-cycle pulses
`timescale 1ns/1ns
interface fence_if;
  logic req_store;
  logic req_load;
  logic store_empty;
  logic loads_done;
  logic busy;
  logic hold_store;
  logic hold_load;
  modport ctrl (output req_store, output req_load, output store_empty, output loads_done,
    input busy, input hold_store, input hold_load);
  modport trk (input req_store, input req_load, input store_empty, input loads_done,
    output busy, output hold_store, output hold_load);
endinterface : fence_if

// File: hw/fence_tracker.sv
// Purpose: data-side memory fences that never stall instruction flow
// Assumes: drain status comes from same-clock memory logic
// Notes: a new request during a wait merges into it
`timescale 1ns/1ns
module fence_tracker (
  input wire logic CLOCK,
  input wire logic RST_B,
  fence_if.trk f
);
  logic wait_store;
  logic wait_load;
  logic next_wait_store;
  logic next_wait_load;
  // Store fence waits on stores only, load fence on loads only
  assign next_wait_store = (wait_store | f.req_store) & ~f.store_empty;
  assign next_wait_load = (wait_load | f.req_load) & ~f.loads_done;
  assign f.busy = wait_store | wait_load;
  // Hold only younger memory accesses of the fenced kind
  assign f.hold_store = wait_store;
  assign f.hold_load = wait_load;
  // Wait flags
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wait_store <= 1'b0;
      wait_load <= 1'b0;
    end else begin
      wait_store <= next_wait_store;
      wait_load <= next_wait_load;
    end
  end
endmodule : fence_tracker

// File: bench/serial_unit_properties.sv
// Purpose: port-level checks for the serialization unit
// Assumes: one clock, async active-low reset
// Notes: op class is tracked from the accept pulse
`include "serial_defines.svh"
`timescale 1ns/1ns
module serial_unit_properties (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic OP_VALID,
  input wire serial_pkg::opc_t OP_CLASS,
  input wire logic OLDER_RETIRED,
  input wire logic STORE_BUF_EMPTY,
  input wire logic WBACK_DONE,
  input wire logic OP_ACCEPT,
  input wire logic FETCH_HOLD,
  input wire logic FLUSH_YOUNGER,
  input wire logic OP_DONE,
  input wire logic ID_REGS_WRITE,
  input wire serial_pkg::word_t PRIMARY_CTRL,
  input wire logic FETCH_PAGING
);
  import serial_pkg::*;
  opc_t pcls;
  opc_t acls;
  // Class at take, then class of the op in flight
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pcls <= `OPC_NONE;
      acls <= `OPC_NONE;
    end else begin
      pcls <= OP_CLASS;
      if (OP_ACCEPT) acls <= pcls;
    end
  end
  // Class groups
  wire is_ser = (pcls >= `OPC_CTRL_WRITE && pcls <= `OPC_SYSTEM_MGMT_RESUME) ||
    pcls == `OPC_BASE_WRITE;
  wire no_stall = (pcls >= `OPC_STORE_FENCE && pcls <= `OPC_FULL_FENCE) || pcls == `OPC_BRANCH;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  property p_acc; OP_ACCEPT |-> $past(OP_VALID) && !$past(FETCH_HOLD); endproperty
  a_acc: assert property (p_acc) else $error("accept without offer");
  property p_ser; OP_ACCEPT && is_ser |-> FLUSH_YOUNGER && FETCH_HOLD; endproperty
  a_ser: assert property (p_ser) else $error("serializer did not stall");
  property p_fen; OP_ACCEPT && no_stall |-> !FETCH_HOLD && !FLUSH_YOUNGER; endproperty
  a_fen: assert property (p_fen) else $error("fence or branch stalled fetch");
  property p_drn; OP_DONE |-> $past(OLDER_RETIRED && STORE_BUF_EMPTY, 2); endproperty
  a_drn: assert property (p_drn) else $error("done before drain");
  property p_rel; OP_DONE |=> !FETCH_HOLD; endproperty
  a_rel: assert property (p_rel) else $error("fetch not released");
  property p_wbi; OP_DONE && acls == `OPC_CACHE_WRITEBACK_INVALIDATE |-> $past(WBACK_DONE, 2);
  endproperty
  a_wbi: assert property (p_wbi) else $error("done before writeback");
  property p_ctl; $changed(PRIMARY_CTRL) |-> OP_DONE; endproperty
  a_ctl: assert property (p_ctl) else $error("control changed outside apply");
  property p_pg; $changed(FETCH_PAGING) |-> $past(OP_DONE) &&
    FETCH_PAGING == PRIMARY_CTRL[`PAGING_BIT]; endproperty
  a_pg: assert property (p_pg) else $error("fetch paging switched early");
  property p_id; ID_REGS_WRITE |-> acls == `OPC_IDENTIFICATION_QUERY && FETCH_HOLD; endproperty
  a_id: assert property (p_id) else $error("stray id register write");
  cover property (OP_DONE && acls == `OPC_CTRL_WRITE);
  cover property (OP_ACCEPT && no_stall);
  cover property (OP_DONE && acls == `OPC_CACHE_WRITEBACK_INVALIDATE);
endmodule : serial_unit_properties
bind serialization_unit serial_unit_properties u_serial_unit_properties (.CLOCK, .RST_B,
  .OP_VALID, .OP_CLASS, .OLDER_RETIRED, .STORE_BUF_EMPTY, .WBACK_DONE, .OP_ACCEPT,
  .FETCH_HOLD, .FLUSH_YOUNGER, .OP_DONE, .ID_REGS_WRITE, .PRIMARY_CTRL, .FETCH_PAGING);

// File: bench/mem_side_model.sv
// Purpose: store buffer, load queue and writeback responder
// Assumes: fills are one-cycle pulses
// Notes: lat sets how slowly the memory side drains
`timescale 1ns/1ns
module mem_side_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic st_fill,
  input wire logic ld_fill,
  input wire logic wback_all,
  input wire logic [7:0] lat,
  output logic store_buf_empty,
  output logic mem_idle,
  output logic loads_done,
  output logic wback_done
);
  logic [7:0] sc;
  logic [7:0] lc;
  logic [2:0] wc;
  // Countdowns of pending stores and loads; writeback counts up to 4
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sc <= 8'h00;
      lc <= 8'h00;
      wc <= 3'h0;
    end else begin
      sc <= st_fill ? lat : sc - 8'(sc != 8'h00);
      lc <= ld_fill ? lat : lc - 8'(lc != 8'h00);
      wc <= wback_all ? wc + 3'(wc != 3'h4) : 3'h0;
    end
  end
  // Status never claims empty early
  assign store_buf_empty = sc == 8'h00;
  assign mem_idle = sc == 8'h00 && lc == 8'h00;
  assign loads_done = lc == 8'h00;
  assign wback_done = wc == 3'h4;
endmodule : mem_side_model

// File: bench/testbench.sv
// Purpose: self-checking bench for the serialization unit
// Assumes: memory side model drains after lat cycles
// Notes: inputs change on the falling edge
`include "serial_defines.svh"
`timescale 1ns/1ns
module testbench;
  import serial_pkg::*;
  logic CLOCK = 0, RST_B = 0, OP_VALID = 0, OLDER_RETIRED = 1, st_fill = 0, ld_fill = 0;
  logic [7:0] lat = 8'h04;
  opc_t OP_CLASS = `OPC_NONE;
  word_t OP_DATA = 32'h0000_0000, PRIMARY_CTRL, PAGE_BASE;
  logic STORE_BUF_EMPTY, MEM_IDLE, LOADS_DONE, WBACK_DONE, OP_ACCEPT, FETCH_HOLD, FLUSH_YOUNGER;
  logic OP_DONE, ID_REGS_WRITE, WBACK_ALL, TLB_FLUSH_NONGLOBAL, STORE_HOLD, LOAD_HOLD;
  logic FETCH_PAGING, FENCE_BUSY, fp_done, got;
  int error_cnt = 0, comparisons = 0, n_id, n_wb, n_tlb, n_done;
  serialization_unit u_serialization_unit (.CLOCK, .RST_B, .OP_VALID, .OP_CLASS, .OP_DATA,
    .OLDER_RETIRED, .STORE_BUF_EMPTY, .MEM_IDLE, .LOADS_DONE, .WBACK_DONE, .OP_ACCEPT,
    .FETCH_HOLD, .FLUSH_YOUNGER, .OP_DONE, .ID_REGS_WRITE, .WBACK_ALL, .TLB_FLUSH_NONGLOBAL,
    .STORE_HOLD, .LOAD_HOLD, .PRIMARY_CTRL, .PAGE_BASE, .FETCH_PAGING, .FENCE_BUSY);
  mem_side_model u_mem_side_model (.clock(CLOCK), .rst_b(RST_B), .st_fill(st_fill),
    .ld_fill(ld_fill), .wback_all(WBACK_ALL), .lat(lat), .store_buf_empty(STORE_BUF_EMPTY),
    .mem_idle(MEM_IDLE), .loads_done(LOADS_DONE), .wback_done(WBACK_DONE));
  // 125 MHz core clock
  always #4 CLOCK = ~CLOCK;
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // One-cycle offers; a refused one is offered again
  task offer(input opc_t c, input word_t d);
    OP_CLASS = c;
    OP_DATA = d;
    got = 0;
    for (int i = 0; i < 20 && !got; i++) begin
      OP_VALID = 1;
      @(negedge CLOCK);
      {OP_VALID, st_fill, ld_fill} = 3'h0;
      got = OP_ACCEPT === 1'h1;
      @(negedge CLOCK);
      got = got || OP_ACCEPT === 1'h1;
    end
    chk(got, 1'h1);
  endtask : offer
  task samp;
    @(negedge CLOCK);
    n_id += int'(ID_REGS_WRITE === 1'h1);
    n_wb += int'(WBACK_ALL === 1'h1);
    n_tlb += int'(TLB_FLUSH_NONGLOBAL === 1'h1);
  endtask : samp
  // Serializer with stores pending; counts side effects up to release
  task run_op(input opc_t c, input word_t d);
    {n_id, n_wb, n_tlb} = 0;
    st_fill = 1;
    offer(c, d);
    chk(FETCH_HOLD, 1'h1);
    for (n_done = 2; n_done < 99 && OP_DONE !== 1'h1; n_done++) samp();
    fp_done = FETCH_PAGING;
    samp();
    chk(FETCH_HOLD, 1'h0);
    chk(n_done > lat, 1'h1);
  endtask : run_op
  task t_serial;
    opc_t c;
    for (int i = 1; i < 15; i++) begin
      c = (i == 14) ? opc_t'(`OPC_BASE_WRITE) : opc_t'(i);
      run_op(c, 32'h0000_0000);
      chk(n_id, c == `OPC_IDENTIFICATION_QUERY);
      chk(n_wb > 0, c == `OPC_CACHE_WRITEBACK_INVALIDATE);
    end
  endtask : t_serial
  // Each fence with its own kind of access outstanding; full fence with both
  task t_fence;
    lat = 8'h0c;
    for (int k = 0; k < 3; k++) begin
      st_fill = k != 1;
      ld_fill = k != 0;
      @(negedge CLOCK);
      offer(opc_t'(`OPC_STORE_FENCE + k), 32'h0000_0000);
      @(negedge CLOCK);
      chk(FETCH_HOLD, 1'h0);
      chk(FENCE_BUSY, 1'h1);
      chk(STORE_HOLD, k != 1);
      chk(LOAD_HOLD, k != 0);
      repeat (14) @(negedge CLOCK);
      chk(FENCE_BUSY, 1'h0);
    end
    lat = 8'h04;
  endtask : t_fence
  // Offers while a serializer waits on retirement are refused
  task t_refuse;
    OLDER_RETIRED = 0;
    offer(`OPC_INTERRUPT_RETURN, 32'h0000_0000);
    OP_CLASS = `OPC_STORE_FENCE;
    OP_VALID = 1;
    n_id = 0;
    repeat (4) begin
      @(negedge CLOCK);
      n_id += int'(OP_ACCEPT === 1'h1 || OP_DONE === 1'h1);
    end
    OP_VALID = 0;
    chk(n_id, 0);
    OLDER_RETIRED = 1;
    repeat (10) @(negedge CLOCK);
    chk(FETCH_HOLD, 1'h0);
  endtask : t_refuse
  task t_paging;
    run_op(`OPC_BASE_WRITE, 32'h0012_3000);
    chk(PAGE_BASE, 32'h0012_3000);
    chk(n_tlb, 0);
    run_op(`OPC_CTRL_WRITE, 32'h8000_0001);
    chk(PRIMARY_CTRL, 32'h8000_0001);
    chk({fp_done, FETCH_PAGING}, 2'h1);
    run_op(`OPC_BASE_WRITE, 32'h0045_6000);
    chk({PAGE_BASE, FETCH_PAGING}, {32'h0045_6000, 1'h1});
    chk(n_tlb, 1);
  endtask : t_paging
  initial begin
    repeat (6) @(negedge CLOCK);
    chk({OP_ACCEPT, FETCH_HOLD, OP_DONE, PRIMARY_CTRL}, 35'h0_0000_0000);
    RST_B = 1;
    @(negedge CLOCK);
    t_serial();
    t_fence();
    t_refuse();
    t_paging();
    print_verdict();
  end
  // Watchdog far past the few hundred cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
